// file: core/dds_device.sv
`timescale 1ns/1ps
`include "dds_regs.svh"
module dds_device (
  // link
  dds_link_if.device link,
  // power-on reset
  input wire logic i_resetn,
  // converter side
  output logic [11:0] o_output_a,
  output logic [11:0] o_output_b,
  output logic o_outputs_on
);

  logic frame_rst_n;
  logic [`DDS_WORD_BITS-2:0] shift_reg;
  logic [`DDS_BIT_CNT_W-1:0] count_reg;
  logic [11:0] out_a_reg;
  logic [11:0] out_b_reg;
  logic shutdown_reg;
  logic shutdown_chan_reg;
  logic load;
  dds_pkg::dds_word_s word;

  // high frame select holds the counter and shifter cleared, so a
  // short frame leaves nothing behind and a new frame needs a low edge
  assign frame_rst_n = i_resetn & ~link.frame_sel_n;

  assign word = {shift_reg, link.serial_data_in};
  assign load = (count_reg == `DDS_LAST_BIT);

  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_reg <= '0;
      count_reg <= '0;
    end else if (count_reg != `DDS_FULL_CNT) begin
      shift_reg <= {shift_reg[`DDS_WORD_BITS-3:0], link.serial_data_in};
      count_reg <= count_reg + 5'h01;
    end
  end

  // converter registers, touched only by a complete word
  always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_a_reg <= `DDS_ZERO_CODE;
      out_b_reg <= `DDS_ZERO_CODE;
    end else if (frame_rst_n && load) begin
      // data still lands while shut down
      if (word.chan) begin
        out_b_reg <= word.sample;
      end else begin
        out_a_reg <= word.sample;
      end
    end
  end

  always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shutdown_reg <= 1'b0;
      shutdown_chan_reg <= 1'b0;
    end else if (frame_rst_n && load) begin
      if (word.shutdown) begin
        shutdown_reg <= 1'b1;
        shutdown_chan_reg <= word.chan;
      end else if (word.chan == shutdown_chan_reg) begin
        shutdown_reg <= 1'b0;
      end
    end
  end

  assign o_output_a = out_a_reg;
  assign o_output_b = out_b_reg;
  // low means a, b and bipolar zero float
  assign o_outputs_on = ~shutdown_reg;
endmodule

// file: core/dds_host.sv
`timescale 1ns/1ps
`include "dds_regs.svh"
module dds_host (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // user request
  input wire logic i_valid,
  input wire logic i_channel_select_bit,
  input wire logic i_shutdown_bit,
  input wire logic [11:0] i_sample_bits,
  output logic o_ready,
  output logic o_done,
  // link
  dds_link_if.host link
);

  localparam logic [2:0] HALF_LAST = 3'(`DDS_HALF_CYCLES - 1);
  localparam logic [2:0] GAP_LAST = 3'(`DDS_GAP_CYCLES - 1);

  dds_pkg::dds_host_state_e state_reg;
  logic [`DDS_WORD_BITS-1:0] shift_reg;
  logic [`DDS_BIT_CNT_W-1:0] bits_left_reg;
  logic [`DDS_TIM_CNT_W-1:0] tim_reg;
  logic sclk_reg;
  logic frame_sel_n_reg;
  logic done_reg;
  logic half_end;
  dds_pkg::dds_word_s word;

  always_comb begin
    word.chan = i_channel_select_bit;
    word.ignored = 1'b0;
    word.shutdown = i_shutdown_bit;
    word.reserved_zero = 1'b0;
    word.sample = i_sample_bits;
  end

  assign half_end = (tim_reg == HALF_LAST);
  assign o_ready = (state_reg == dds_pkg::DDS_IDLE);
  assign o_done = done_reg;
  assign link.sclk = sclk_reg;
  assign link.frame_sel_n = frame_sel_n_reg;
  assign link.serial_data_in = shift_reg[`DDS_WORD_BITS-1];

  // frame sequencing
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= dds_pkg::DDS_IDLE;
      frame_sel_n_reg <= 1'b1;
      bits_left_reg <= '0;
      tim_reg <= '0;
      sclk_reg <= 1'b0;
      shift_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        dds_pkg::DDS_IDLE: begin
          tim_reg <= '0;
          sclk_reg <= 1'b0;
          if (i_valid) begin
            // falling frame select opens the frame, data bit 15 set up
            state_reg <= dds_pkg::DDS_SHIFT;
            frame_sel_n_reg <= 1'b0;
            shift_reg <= word;
            bits_left_reg <= `DDS_LAST_BIT;
          end
        end
        dds_pkg::DDS_SHIFT: begin
          // both halves at least 15 ns, period at least 30 ns
          tim_reg <= half_end ? '0 : tim_reg + 3'h1;
          if (half_end) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              if (bits_left_reg == '0) begin
                // raise after the 16th rising edge
                state_reg <= dds_pkg::DDS_GAP;
                frame_sel_n_reg <= 1'b1;
                done_reg <= 1'b1;
              end else begin
                bits_left_reg <= bits_left_reg - 5'h01;
                shift_reg <= {shift_reg[`DDS_WORD_BITS-2:0], 1'b0};
              end
            end
          end
        end
        dds_pkg::DDS_GAP: begin
          // keep frame select high before the next frame
          tim_reg <= tim_reg + 3'h1;
          if (tim_reg == GAP_LAST) begin
            state_reg <= dds_pkg::DDS_IDLE;
          end
        end
        default: begin
          state_reg <= dds_pkg::DDS_IDLE;
          frame_sel_n_reg <= 1'b1;
        end
      endcase
    end
  end

endmodule

// file: core/dds_link_if.sv
`timescale 1ns/1ps
interface dds_link_if;
  logic sclk;
  logic frame_sel_n;
  logic serial_data_in;

  modport host (
    output sclk,
    output frame_sel_n,
    output serial_data_in
  );

  modport device (
    input sclk,
    input frame_sel_n,
    input serial_data_in
  );
endinterface

// file: core/dds_pkg.sv
package dds_pkg;

  // 16-bit word, first bit on the wire is chan
  typedef struct packed {
    logic chan;
    logic ignored;
    logic shutdown;
    logic reserved_zero;
    logic [11:0] sample;
  } dds_word_s;

  typedef enum logic [1:0] {
    DDS_IDLE = 2'h0,
    DDS_SHIFT = 2'h1,
    DDS_GAP = 2'h3
  } dds_host_state_e;

endpackage

// file: core/dds_regs.svh
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH

// serial word shape
`define DDS_WORD_BITS 16
`define DDS_SAMPLE_BITS 12
`define DDS_BIT_CNT_W 5
`define DDS_LAST_BIT 5'h0F
`define DDS_FULL_CNT 5'h10
`define DDS_ZERO_CODE 12'h000

// host timing: limits in ns, half and gap lengths in i_clk cycles, counter width in bits
`define DDS_CLK_NS 10
`define DDS_SCLK_MIN_NS 30
`define DDS_CS_HIGH_MIN_NS 30
`define DDS_HALF_CYCLES ((`DDS_SCLK_MIN_NS + 2 * `DDS_CLK_NS - 1) / (2 * `DDS_CLK_NS))
`define DDS_GAP_CYCLES ((`DDS_CS_HIGH_MIN_NS + `DDS_CLK_NS - 1) / `DDS_CLK_NS)
`define DDS_TIM_CNT_W 3

`endif

// file: verif/dds_link_asserts.sv
`timescale 1ns/1ps
module dds_link_asserts (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic serial_data_in
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_close;
    ##62 $rose(sclk) ##2 $rose(frame_sel_n);
  endsequence
  property p_idle; o_ready |-> frame_sel_n && !sclk; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_open; $fell(frame_sel_n) |=> !sclk ##1 sclk; endproperty
  a_open: assert property (p_open) else $error("open");
  property p_half; $rose(sclk) |=> sclk ##1 !sclk; endproperty
  a_half: assert property (p_half) else $error("half");
  property p_data; $rose(sclk) |-> $stable(serial_data_in); endproperty
  a_data: assert property (p_data) else $error("data");
  property p_count; $fell(frame_sel_n) |-> s_close; endproperty
  a_count: assert property (p_count) else $error("count");
  property p_done; o_done == $rose(frame_sel_n); endproperty
  a_done: assert property (p_done) else $error("done");
  property p_gap; $rose(frame_sel_n) |-> frame_sel_n[*3]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_zero; $fell(frame_sel_n) |-> ##4 !serial_data_in ##8 !serial_data_in; endproperty
  a_zero: assert property (p_zero) else $error("zero");
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic i_clk = 0, i_resetn, i_valid = 0, ch = 0, sd = 0;
  logic [11:0] smp = 12'h000, a1, b1;
  logic o_ready, o_done, on1;
  int num_errors = 0, cmp_count = 0, ea = 0, eb = 0, eon = 1, sch = 0;
  dds_link_if lk ();
  dds_host dds_host_inst (.i_clk, .i_resetn, .i_valid, .i_channel_select_bit(ch),
    .i_shutdown_bit(sd), .i_sample_bits(smp), .o_ready, .o_done, .link(lk.host));
  dds_device dds_device_inst (.link(lk.device), .i_resetn, .o_output_a(a1),
    .o_output_b(b1), .o_outputs_on(on1));
  dds_link_asserts dds_link_asserts_inst (.i_clk, .i_resetn, .o_ready, .o_done,
    .sclk(lk.sclk), .frame_sel_n(lk.frame_sel_n), .serial_data_in(lk.serial_data_in));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic send(input logic c, input logic s, input logic [11:0] d);
    int k = 0;
    @(negedge i_clk);
    chk({24'h000000, o_ready}, 25'h0000001);
    @(posedge i_clk);
    ch <= c;
    sd <= s;
    smp <= d;
    i_valid <= 1'b1;
    @(posedge i_clk);
    i_valid <= 1'b0;
    while (o_done !== 1'b1 && k < 99) begin
      @(negedge i_clk);
      k++;
    end
    // a missing done pulse or a ready host in the gap counts here
    chk({23'h000000, o_ready, o_done}, 25'h0000001);
    // o_ready returns three edges after o_done
    repeat (3) @(posedge i_clk);
    if (c) eb = d;
    else ea = d;
    if (s) sch = c;
    eon = s ? 0 : (c == sch) ? 1 : eon;
    chk({on1, a1, b1}, {eon[0], ea[11:0], eb[11:0]});
  endtask
  initial begin
    #60000;
    num_errors++;
    test_done;
  end
  initial begin
    // from unknown to low, so the device registers see a reset edge
    i_resetn <= 1'b0;
    void'($urandom(32'h3EC279DE));
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk({on1, a1, b1}, 25'h1000000);
    send(1'b0, 1'b1, 12'h5A5);
    send(1'b1, 1'b0, 12'hFFF);
    send(1'b0, 1'b0, 12'h001);
    send(1'b1, 1'b1, 12'h3C3);
    send(1'b0, 1'b0, 12'h7E7);
    send(1'b1, 1'b0, 12'h800);
    repeat (12) send(1'($urandom), 1'b0, 12'($urandom));
    test_done;
  end
endmodule
